// ==== core/mac_pcs_link_status_regs.sv ====
// mac-side serdes pcs status, ability and event registers on extended page 3
// What this block does
// - status bit 11 shows partner requested autonegotiation restart
// - status bits 9:8 carry mac remote fault; 00 means none
// - status bit 7 shows mac advertises asymmetric pause
// - status bit 6 shows mac advertises symmetric pause
// - status bit 5 shows mac advertises full duplex
// - status bit 4 shows mac advertises half duplex
// - status bit 3 shows partner is autonegotiation capable
// - status bit 2 is one while mac-side link is up
// - status bit 1 is one once mac-side autonegotiation completes
// - status bit 0 is one while pcs sees valid incoming signal
// - advertised code word register readable, resets to zero
// - advertised register writable only while force bit set, else tracks internal word
// - read-only register holds last code word received from partner
// - serdes status bit 14 is sticky signal-detect event flag
// - with force bit set, the register value is advertised
`timescale 1ns/1ps
module mac_pcs_link_status_regs
(
	input  wire logic        clk,             // 25 MHz management clock
	input  wire logic        rstn,            // async reset, active low
	input  wire logic [4:0]  mgmt_addr,       // register number 0..31
	input  wire logic        mgmt_wr,         // write strobe, one cycle
	input  wire logic        mgmt_rd,         // read strobe, one cycle
	input  wire logic [15:0] mgmt_wdata,      // write data
	output logic      [15:0] mgmt_rdata,      // read data, one cycle after mgmt_rd
	output logic      [15:0] page_sel,        // current page select value
	input  wire logic        lp_an_restart,   // partner restart request seen
	input  wire logic [1:0]  mac_rfault,      // remote fault from mac ability
	input  wire logic        mac_asym_pause,  // mac advertises asymmetric pause
	input  wire logic        mac_sym_pause,   // mac advertises symmetric pause
	input  wire logic        mac_full_dup,    // mac advertises full duplex
	input  wire logic        mac_half_dup,    // mac advertises half duplex
	input  wire logic        lp_an_capable,   // partner can autonegotiate
	input  wire logic        mac_link_up,     // mac-side link connected
	input  wire logic        an_complete,     // autonegotiation complete
	input  wire logic        pcs_sig_det,     // pcs signal detect level
	input  wire logic [15:0] gen_code_word,   // internally generated code word
	input  wire logic [15:0] rx_code_word,    // received config code word
	input  wire logic        rx_code_valid,   // rx_code_word valid, one cycle
	input  wire logic        sig_det_event,   // serdes signal detect event pulse
	input  wire logic        qsgmii_sync,     // qsgmii receiver synchronised
	output logic      [15:0] advert_word,     // code word sent to the mac
	output logic             force_advert,    // force advertised ability active
	output logic             an_restart       // restart mac autonegotiation, pulse
);

	// control field bounds, all derived from package positions
	localparam int TOP     = pcs_status_pkg::REG_DW - 1;
	localparam int HI_LSB  = pcs_status_pkg::CTRL_AN_RESTART_BIT + 1;
	localparam int MID_MSB = pcs_status_pkg::CTRL_FORCE_ADV_BIT - 1;
	localparam int LO      = pcs_status_pkg::CTRL_LO_BIT;

	logic [TOP:HI_LSB] ctrl_hi_r;
	logic [MID_MSB:LO] ctrl_mid_r;

	logic [15:0] page_r;
	logic        force_r;
	logic [15:0] ctrl_word;
	// status field registers
	logic        lp_restart_r;
	logic [1:0]  rfault_r;
	logic        asym_pause_r;
	logic        sym_pause_r;
	logic        full_dup_r;
	logic        half_dup_r;
	logic        lp_an_cap_r;
	logic        link_up_r;
	logic        an_done_r;
	logic        sig_det_r;
	logic [15:0] link_stat_word;
	logic [15:0] event_word;
	logic [15:0] local_advert_r;
	logic [15:0] partner_code_r;
	logic        sig_det_sticky_r;
	logic        qsgmii_sync_r;
	logic [15:0] rdata_r;
	logic        an_restart_r;
	logic        on_page3;
	logic        wr_ctrl;
	logic        wr_advert;
	logic        rd_event;
	logic [15:0] rdata_nxt;
	logic [15:0] page3_word;
	logic        wr_page;

	assign on_page3 = (page_r == pcs_status_pkg::PAGE_EXT3);
	assign wr_ctrl  = mgmt_wr && on_page3
		&& (mgmt_addr == pcs_status_pkg::PCS_CTRL_ADDR);
	assign wr_advert = mgmt_wr && on_page3
		&& (mgmt_addr == pcs_status_pkg::LOCAL_ADVERT_ADDR);
	assign rd_event = mgmt_rd && on_page3
		&& (mgmt_addr == pcs_status_pkg::SERDES_EVENT_ADDR);
	assign wr_page  = mgmt_wr && (mgmt_addr == pcs_status_pkg::PAGE_SEL_ADDR);

	// page select is always reachable, whatever page is active
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			page_r <= pcs_status_pkg::PAGE_RESET;
		else if (wr_page)
			page_r <= mgmt_wdata;
	end

	// restart bit never stored, so it reads back as zero (self-clearing)
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			ctrl_hi_r <= pcs_status_pkg::CTRL_RESET[TOP:HI_LSB];
		else if (wr_ctrl)
			ctrl_hi_r <= mgmt_wdata[TOP:HI_LSB];
	end

	// force bit also picks what the advertised word follows
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			force_r <= pcs_status_pkg::CTRL_RESET[pcs_status_pkg::CTRL_FORCE_ADV_BIT];
		else if (wr_ctrl)
			force_r <= mgmt_wdata[pcs_status_pkg::CTRL_FORCE_ADV_BIT];
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			ctrl_mid_r <= pcs_status_pkg::CTRL_RESET[MID_MSB:LO];
		else if (wr_ctrl)
			ctrl_mid_r <= mgmt_wdata[MID_MSB:LO];
	end

	// restart bit 12 and bits 4:0 read as zero
	always_comb
	begin
		ctrl_word = pcs_status_pkg::ZERO_WORD;
		ctrl_word[TOP:HI_LSB] = ctrl_hi_r;
		ctrl_word[pcs_status_pkg::CTRL_FORCE_ADV_BIT] = force_r;
		ctrl_word[MID_MSB:LO] = ctrl_mid_r;
	end

	// one-cycle pulse to the pcs; no handshake back
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			an_restart_r <= 1'b0;
		else
			an_restart_r <= wr_ctrl && mgmt_wdata[pcs_status_pkg::CTRL_AN_RESTART_BIT];
	end

	// status inputs share this clock, so no synchroniser stages
	// status fields, each one cycle behind its pcs input
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			lp_restart_r <= 1'b0;
		else
			lp_restart_r <= lp_an_restart;
	end

	// any non-zero fault code is passed through untouched
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rfault_r <= 2'b00;
		else
			rfault_r <= mac_rfault;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			asym_pause_r <= 1'b0;
		else
			asym_pause_r <= mac_asym_pause;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			sym_pause_r <= 1'b0;
		else
			sym_pause_r <= mac_sym_pause;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			full_dup_r <= 1'b0;
		else
			full_dup_r <= mac_full_dup;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			half_dup_r <= 1'b0;
		else
			half_dup_r <= mac_half_dup;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			lp_an_cap_r <= 1'b0;
		else
			lp_an_cap_r <= lp_an_capable;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			link_up_r <= 1'b0;
		else
			link_up_r <= mac_link_up;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			an_done_r <= 1'b0;
		else
			an_done_r <= an_complete;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			sig_det_r <= 1'b0;
		else
			sig_det_r <= pcs_sig_det;
	end

	// reserved bits 15:12 and 10 stay zero
	always_comb
	begin
		link_stat_word = pcs_status_pkg::ZERO_WORD;
		link_stat_word[pcs_status_pkg::LS_LP_RESTART_BIT] = lp_restart_r;
		link_stat_word[pcs_status_pkg::LS_RFAULT_HI:pcs_status_pkg::LS_RFAULT_LO]
			= rfault_r;
		link_stat_word[pcs_status_pkg::LS_ASYM_PAUSE_BIT] = asym_pause_r;
		link_stat_word[pcs_status_pkg::LS_SYM_PAUSE_BIT] = sym_pause_r;
		link_stat_word[pcs_status_pkg::LS_FULL_DUP_BIT] = full_dup_r;
		link_stat_word[pcs_status_pkg::LS_HALF_DUP_BIT] = half_dup_r;
		link_stat_word[pcs_status_pkg::LS_LP_AN_CAP_BIT] = lp_an_cap_r;
		link_stat_word[pcs_status_pkg::LS_LINK_BIT] = link_up_r;
		link_stat_word[pcs_status_pkg::LS_AN_DONE_BIT] = an_done_r;
		link_stat_word[pcs_status_pkg::LS_SIG_DET_BIT] = sig_det_r;
	end

	// forced: holds software's value; otherwise follows the generated word
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			local_advert_r <= pcs_status_pkg::ADVERT_RESET;
		else if (force_r)
		begin
			if (wr_advert)
				local_advert_r <= mgmt_wdata;
		end
		else
			local_advert_r <= gen_code_word;
	end

	// holds between strobes, so a late read still shows the last word
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			partner_code_r <= pcs_status_pkg::ZERO_WORD;
		else if (rx_code_valid)
			partner_code_r <= rx_code_word;
	end

	// a new event beats a clearing read in the same cycle
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			sig_det_sticky_r <= 1'b0;
		else if (sig_det_event)
			sig_det_sticky_r <= 1'b1;
		else if (rd_event)
			sig_det_sticky_r <= 1'b0;
	end

	// plain level, read one cycle late like the other status bits
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			qsgmii_sync_r <= 1'b0;
		else
			qsgmii_sync_r <= qsgmii_sync;
	end

	// bit 15 and bits 12:0 are reserved and read zero
	always_comb
	begin
		event_word = pcs_status_pkg::ZERO_WORD;
		event_word[pcs_status_pkg::EV_SIG_DET_BIT] = sig_det_sticky_r;
		event_word[pcs_status_pkg::EV_QSGMII_SYNC_BIT] = qsgmii_sync_r;
	end

	// page 3 window; anything outside 0x10..0x14 reads zero
	always_comb
	begin
		page3_word = pcs_status_pkg::ZERO_WORD;
		unique case (mgmt_addr)
			pcs_status_pkg::PCS_CTRL_ADDR:      page3_word = ctrl_word;
			pcs_status_pkg::PCS_LINK_STAT_ADDR: page3_word = link_stat_word;
			pcs_status_pkg::LOCAL_ADVERT_ADDR:  page3_word = local_advert_r;
			pcs_status_pkg::PARTNER_CODE_ADDR:  page3_word = partner_code_r;
			pcs_status_pkg::SERDES_EVENT_ADDR:  page3_word = event_word;
			default:                            page3_word = pcs_status_pkg::ZERO_WORD;
		endcase
	end

	// unmapped addresses and other pages read as zero, except page select at 0x1F on any page
	always_comb
	begin
		rdata_nxt = pcs_status_pkg::ZERO_WORD;
		if (mgmt_addr == pcs_status_pkg::PAGE_SEL_ADDR)
			rdata_nxt = page_r;
		else if (on_page3)
			rdata_nxt = page3_word;
	end

	// read data holds between reads so software may sample late
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rdata_r <= pcs_status_pkg::ZERO_WORD;
		else if (mgmt_rd)
			rdata_r <= rdata_nxt;
	end

	assign mgmt_rdata   = rdata_r;
	assign page_sel     = page_r;
	assign advert_word  = local_advert_r;
	assign force_advert = force_r;
	assign an_restart   = an_restart_r;

endmodule // mac_pcs_link_status_regs

// ==== core/pcs_status_pkg.sv ====
// constants for the mac-side serdes pcs status register page
package pcs_status_pkg;
	localparam int          REG_AW              = 5;
	localparam int          REG_DW              = 16;
	// page select register and page codes
	localparam logic [4:0]  PAGE_SEL_ADDR       = 5'h1F;
	localparam logic [15:0] PAGE_MAIN           = 16'h0000;
	localparam logic [15:0] PAGE_EXT3           = 16'h0003;
	localparam logic [15:0] PAGE_RESET          = 16'h0000;
	// extended page 3 offsets
	localparam logic [4:0]  PCS_CTRL_ADDR       = 5'h10;
	localparam logic [4:0]  PCS_LINK_STAT_ADDR  = 5'h11;
	localparam logic [4:0]  LOCAL_ADVERT_ADDR   = 5'h12;
	localparam logic [4:0]  PARTNER_CODE_ADDR   = 5'h13;
	localparam logic [4:0]  SERDES_EVENT_ADDR   = 5'h14;
	// pcs control fields
	localparam int          CTRL_AN_RESTART_BIT = 12;
	localparam int          CTRL_FORCE_ADV_BIT  = 11;
	localparam int          CTRL_LO_BIT         = 5;
	localparam logic [15:0] CTRL_RESET          = 16'h0100;
	localparam logic [15:0] CTRL_WR_MASK        = 16'hEFE0;
	// pcs link status fields
	localparam int          LS_LP_RESTART_BIT   = 11;
	localparam int          LS_RFAULT_HI        = 9;
	localparam int          LS_RFAULT_LO        = 8;
	localparam int          LS_ASYM_PAUSE_BIT   = 7;
	localparam int          LS_SYM_PAUSE_BIT    = 6;
	localparam int          LS_FULL_DUP_BIT     = 5;
	localparam int          LS_HALF_DUP_BIT     = 4;
	localparam int          LS_LP_AN_CAP_BIT    = 3;
	localparam int          LS_LINK_BIT         = 2;
	localparam int          LS_AN_DONE_BIT      = 1;
	localparam int          LS_SIG_DET_BIT      = 0;
	// serdes event status fields
	localparam int          EV_SIG_DET_BIT      = 14;
	localparam int          EV_QSGMII_SYNC_BIT  = 13;
	// reset values
	localparam logic [15:0] ADVERT_RESET        = 16'h0000;
	localparam logic [15:0] ZERO_WORD           = 16'h0000;
endpackage

// ==== dv/pcs_status_monitor.sv ====
// assertions on the pcs status page ports
`timescale 1ns/1ps
module pcs_status_monitor
(
	input wire logic        clk,           // clock
	input wire logic        rstn,          // reset, active low
	input wire logic        mgmt_wr,       // write strobe
	input wire logic        mgmt_rd,       // read strobe
	input wire logic        mac_link_up,   // link level
	input wire logic        rx_code_valid, // word strobe
	input wire logic        sig_det_event, // detect event
	input wire logic        force_advert,  // force bit
	input wire logic [4:0]  mgmt_addr,     // register
	input wire logic [1:0]  mac_rfault,    // fault field
	input wire logic [15:0] mgmt_wdata,    // write data
	input wire logic [15:0] mgmt_rdata,    // read data
	input wire logic [15:0] page_sel,      // page value
	input wire logic [15:0] gen_code_word, // generated word
	input wire logic [15:0] rx_code_word,  // received word
	input wire logic [15:0] advert_word    // advertised word
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	wire pg3 = page_sel == 16'h0003;
	sequence rd_at(a);
		mgmt_rd && mgmt_addr == a && pg3;
	endsequence
	pg_sel_a: assert property (
		mgmt_wr && mgmt_addr == 5'h1F |=> page_sel == $past(mgmt_wdata)) else $error("page");
	off_page_a: assert property (
		mgmt_rd && !pg3 && mgmt_addr == 5'h12 |=> mgmt_rdata == 16'h0000) else $error("off");
	link_bit_a: assert property (
		rd_at(5'h11) ##0 $stable(mac_link_up) |=> mgmt_rdata[2] == $past(mac_link_up))
		else $error("link");
	fault_fld_a: assert property (
		rd_at(5'h11) ##0 $stable(mac_rfault) |=> mgmt_rdata[9:8] == $past(mac_rfault))
		else $error("fault");
	rsvd_stat_a: assert property (
		rd_at(5'h11) |=> mgmt_rdata[15:12] == 4'h0 && !mgmt_rdata[10]) else $error("rsvd");
	adv_hold_a: assert property (
		force_advert && !mgmt_wr |=> $stable(advert_word)) else $error("hold");
	adv_track_a: assert property (
		!force_advert && !mgmt_wr |=> advert_word == $past(gen_code_word)) else $error("track");
	adv_write_a: assert property (
		force_advert && mgmt_wr && mgmt_addr == 5'h12 && pg3
		|=> advert_word == $past(mgmt_wdata)) else $error("write");
	det_set_a: assert property (
		sig_det_event ##1 rd_at(5'h14) |=> mgmt_rdata[14]) else $error("set");
	det_clr_a: assert property (
		rd_at(5'h14) ##0 !sig_det_event ##1 !sig_det_event ##1 rd_at(5'h14) ##0 !sig_det_event
		|=> !mgmt_rdata[14]) else $error("clear");
	rx_word_a: assert property (
		rx_code_valid ##1 !rx_code_valid ##1 rd_at(5'h13) ##0 !rx_code_valid
		|=> mgmt_rdata == $past(rx_code_word, 3)) else $error("rx");
endmodule // pcs_status_monitor

// ==== dv/mac_pcs_partner.sv ====
// mac-side partner: status levels, code words, detect events
`timescale 1ns/1ps
module mac_pcs_partner
(
	input  wire logic [15:0] ab,             // state in status layout
	input  wire logic [15:0] cw,             // code word to send
	input  wire logic        send,           // word strobe
	input  wire logic        ev,             // detect event
	output logic             lp_an_restart,  // restart request
	output logic             mac_asym_pause, // asymmetric pause
	output logic             mac_sym_pause,  // symmetric pause
	output logic             mac_full_dup,   // full duplex
	output logic             mac_half_dup,   // half duplex
	output logic             lp_an_capable,  // can autonegotiate
	output logic             mac_link_up,    // link level
	output logic             an_complete,    // negotiation done
	output logic             pcs_sig_det,    // signal level
	output logic             rx_code_valid,  // word strobe
	output logic             sig_det_event,  // detect event
	output logic             qsgmii_sync,    // sync level
	output logic      [1:0]  mac_rfault,     // fault
	output logic      [15:0] rx_code_word    // word lines
);
	assign {lp_an_restart, mac_rfault, mac_asym_pause, mac_sym_pause, mac_full_dup,
		mac_half_dup, lp_an_capable, mac_link_up, an_complete, pcs_sig_det} = {ab[11], ab[9:0]};
	assign qsgmii_sync = ab[13];
	assign sig_det_event = ev;
	assign rx_code_valid = send;
	// idle at the inverse so a capture off the strobe shows
	assign rx_code_word = send ? cw : ~cw;
endmodule // mac_pcs_partner

// ==== dv/mac_pcs_link_status_regs_tb.sv ====
// testbench for the pcs status register page
`timescale 1ns/1ps
module mac_pcs_link_status_regs_tb;
	logic        clk = 0, rstn = 0, mgmt_wr = 0, mgmt_rd = 0, send = 0, ev = 0;
	logic [4:0]  mgmt_addr = 5'h00;
	logic [15:0] mgmt_wdata = 16'h0000, gen_code_word = 16'h0000, ab = 16'h0000, cw = 16'h0000;
	logic [15:0] mgmt_rdata, page_sel, advert_word, rx_code_word;
	logic [1:0]  mac_rfault;
	logic        lp_an_restart, mac_asym_pause, mac_sym_pause, mac_full_dup, mac_half_dup;
	logic        lp_an_capable, mac_link_up, an_complete, pcs_sig_det, rx_code_valid;
	logic        sig_det_event, qsgmii_sync, force_advert, an_restart;
	int          bad_count = 0, checks = 0;
	always #20 clk = ~clk;
	mac_pcs_link_status_regs mac_pcs_link_status_regs_inst (.*);
	mac_pcs_partner mac_pcs_partner_inst (.*);
	task automatic chk(input logic [15:0] seen, exp);
		checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(negedge clk) {mgmt_addr, mgmt_wdata, mgmt_wr} = {a, d, 1'b1};
		@(negedge clk) mgmt_wr = 1'b0;
	endtask
	task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
		@(negedge clk) {mgmt_addr, mgmt_rd} = {a, 1'b1};
		@(negedge clk) mgmt_rd = 1'b0;
		chk(mgmt_rdata, exp);
	endtask
	task automatic give_verdict;
		$display("checks=%0d mismatches=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(negedge clk);
		chk(advert_word, 16'h0000);
		rstn = 1'b1;
		rdc(5'h12, 16'h0000);
		wr(5'h1F, 16'h0003);
		for (int i = 0; i < 17; i++)
		begin
			ab = (i == 16) ? 16'hFFFF : 16'h0001 << i;
			rdc(5'h11, ab & 16'h0BFF);
			rdc(5'h14, ab & 16'h2000);
		end
		$display("status test done");
		ab = 16'h0000;
		gen_code_word = 16'hA5C3;
		rdc(5'h12, 16'hA5C3);
		wr(5'h12, 16'h1234);
		rdc(5'h12, 16'hA5C3);
		wr(5'h10, 16'h0800);
		chk({15'h0000, force_advert}, 16'h0001);
		gen_code_word = 16'h5A3C;
		rdc(5'h12, 16'hA5C3);
		wr(5'h12, 16'h1234);
		rdc(5'h12, 16'h1234);
		chk(advert_word, 16'h1234);
		wr(5'h10, 16'h0000);
		rdc(5'h12, 16'h5A3C);
		$display("advert test done");
		wr(5'h10, 16'hF7E0);
		chk({15'h0000, an_restart}, 16'h0001);
		rdc(5'h10, 16'hE7E0);
		chk({15'h0000, an_restart}, 16'h0000);
		wr(5'h10, 16'h0000);
		$display("control test done");
		cw = 16'hBEEF;
		@(negedge clk) send = 1'b1;
		@(negedge clk) send = 1'b0;
		rdc(5'h13, 16'hBEEF);
		$display("code word test done");
		rdc(5'h14, 16'h0000);
		ev = 1'b1;
		rdc(5'h14, 16'h4000);
		ev = 1'b0;
		rdc(5'h14, 16'h4000);
		rdc(5'h14, 16'h0000);
		$display("event test done");
		wr(5'h1F, 16'h0000);
		rdc(5'h1F, 16'h0000);
		rdc(5'h12, 16'h0000);
		$display("page test done");
		give_verdict();
	end
	initial
	begin
		repeat (2000) @(posedge clk);
		bad_count++;
		give_verdict();
	end
endmodule // mac_pcs_link_status_regs_tb
bind mac_pcs_link_status_regs pcs_status_monitor pcs_status_monitor_inst (
	.clk(clk), .rstn(rstn), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
	.mac_link_up(mac_link_up), .rx_code_valid(rx_code_valid),
	.sig_det_event(sig_det_event), .force_advert(force_advert),
	.mgmt_addr(mgmt_addr), .mac_rfault(mac_rfault), .mgmt_wdata(mgmt_wdata),
	.mgmt_rdata(mgmt_rdata), .page_sel(page_sel), .gen_code_word(gen_code_word),
	.rx_code_word(rx_code_word), .advert_word(advert_word));
